// ==== hdl/svrf_pkg.sv ====
// Shared constants for the vector register file: views, element tags,
// lane geometry and the scalar reach limits of multiply operands.
// Assumes a single core clock and a synchronous reset.
`default_nettype none
package svrf_pkg;
	// Storage geometry
	localparam int QUAD_W = 128;
	localparam int DBL_W = 64;
	localparam int SGL_W = 32;
	localparam int NUM_QUAD = 16;
	localparam int NUM_DBL_FULL = 32;
	localparam int NUM_DBL_SMALL = 16;
	localparam int NUM_SGL = 32;
	// Multiply scalar reach
	localparam int MUL16_MAX_REG = 7;
	localparam int MUL16_MAX_LANE = 3;
	localparam int MUL32_MAX_REG = 15;
	localparam int MUL32_MAX_LANE = 1;
	// Reset value of the storage
	localparam logic [127:0] STORE_RESET = 128'h0;

	// Access view chosen by the issuing instruction
	typedef enum logic [1:0]
	{
		SVRF_VIEW_S = 2'h0,
		SVRF_VIEW_D = 2'h1,
		SVRF_VIEW_Q = 2'h2
	} svrf_view_t;

	// Element width code
	typedef enum logic [1:0]
	{
		SVRF_W8 = 2'h0,
		SVRF_W16 = 2'h1,
		SVRF_W32 = 2'h2,
		SVRF_W64 = 2'h3
	} svrf_width_t;

	// Interpretation letter of an element-type tag
	typedef enum logic [2:0]
	{
		SVRF_K_UNSIGNED = 3'h0,
		SVRF_K_SIGNED = 3'h1,
		SVRF_K_UNTYPED = 3'h2,
		SVRF_K_FLOAT = 3'h3,
		SVRF_K_POLY = 3'h4
	} svrf_kind_t;

	// Requesting client
	typedef enum logic [1:0]
	{
		SVRF_C_INT = 2'h0,
		SVRF_C_FLT = 2'h1,
		SVRF_C_LSP = 2'h2,
		SVRF_C_SFP = 2'h3
	} svrf_client_t;

	// Lane operation of the execute path
	typedef enum logic [1:0]
	{
		SVRF_OP_PASS = 2'h0,
		SVRF_OP_ADD = 2'h1,
		SVRF_OP_SUB = 2'h2,
		SVRF_OP_INS = 2'h3
	} svrf_op_t;
endpackage : svrf_pkg
`default_nettype wire

// ==== hdl/svrf_tag_check.sv ====
// Element-type tag checker: tells whether an interpretation and width pair
// is legal for the vector side or for the scalar floating-point side.
// Pure combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module svrf_tag_check
(
	// Tag in
	input wire svrf_pkg::svrf_kind_t kind,
	input wire svrf_pkg::svrf_width_t width,
	input wire logic scalar_fp,
	input wire logic half_opt,
	// Verdict
	output logic legal
);
	// Vector table and scalar table differ in 8 and 64 bit reach
	always_comb
	begin
		legal = 1'b0;
		if (!scalar_fp)
		begin
			case (kind)
				svrf_pkg::SVRF_K_UNSIGNED,
				svrf_pkg::SVRF_K_SIGNED,
				svrf_pkg::SVRF_K_UNTYPED: legal = 1'b1;
				svrf_pkg::SVRF_K_FLOAT: legal = (width == svrf_pkg::SVRF_W16) ||
					(width == svrf_pkg::SVRF_W32);
				svrf_pkg::SVRF_K_POLY: legal = (width == svrf_pkg::SVRF_W8) ||
					(width == svrf_pkg::SVRF_W16);
				default: legal = 1'b0;
			endcase
		end
		else
		begin
			case (kind)
				svrf_pkg::SVRF_K_UNSIGNED,
				svrf_pkg::SVRF_K_SIGNED: legal = (width == svrf_pkg::SVRF_W16) ||
					(width == svrf_pkg::SVRF_W32);
				svrf_pkg::SVRF_K_FLOAT: legal = (width == svrf_pkg::SVRF_W32) ||
					(width == svrf_pkg::SVRF_W64) ||
					((width == svrf_pkg::SVRF_W16) && half_opt);
				default: legal = 1'b0;
			endcase
		end
	end
endmodule : svrf_tag_check
`default_nettype wire

// ==== hdl/svrf_lane_alu.sv ====
// Lane-partitioned 64-bit adder/subtractor. Each lane is computed on its
// own; the carry chain is cut at every lane boundary of the chosen width.
// Pure combinational.
`timescale 1ns/100ps
`default_nettype none
module svrf_lane_alu
(
	// Operands
	input wire logic [63:0] a,
	input wire logic [63:0] b,
	input wire logic sub,
	input wire svrf_pkg::svrf_width_t width,
	// Result
	output logic [63:0] y
);
	logic [8:0] carry;
	logic [63:0] bx;

	// Invert b for subtraction so each lane forms a + ~b + 1
	assign bx = sub ? ~b : b;
	assign carry[0] = sub;

	// One byte slice per step; carry restarts where a lane begins
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_byte
			logic [8:0] s;
			logic cin;
			logic lane_start;
			always_comb
			begin
				case (width)
					svrf_pkg::SVRF_W8: lane_start = 1'b1;
					svrf_pkg::SVRF_W16: lane_start = (i % 2) == 0;
					svrf_pkg::SVRF_W32: lane_start = (i % 4) == 0;
					default: lane_start = (i == 0);
				endcase
			end
			assign cin = lane_start ? sub : carry[i];
			assign s = {1'b0, a[8*i +: 8]} + {1'b0, bx[8*i +: 8]} + {8'h0, cin};
			assign y[8*i +: 8] = s[7:0];
			assign carry[i+1] = s[8];
		end
	endgenerate
endmodule : svrf_lane_alu
`default_nettype wire

// ==== hdl/svrf_regfile.sv ====
// Shared vector and floating-point register file with quad, double and
// single views, lane-wise execute path and scalar element access.
// Assumes clients present one request per cycle per port, same clock.
// What this block does
// - Reads and writes at 32, 64 and 128 bit over one storage.
// - Lane arithmetic never carries or borrows into the next lane.
// - A 64-bit vector splits into 8, 4, 2 or 1 lanes.
// - A 128-bit vector splits into 16, 8, 4 or 2 lanes.
// - Lane zero sits in the lowest bits, higher lanes above it.
// - Quad view offers sixteen 128-bit registers, 0 to 15.
// - Double view offers 32 registers, or 16 when reduced.
// - Double 2n is quad n low half, 2n+1 the high half.
// - Single 2n is double n low half, 2n+1 the high half.
// - Vector pipelines have no single-view port; scalar FP only.
// - Every view usable any time; the instruction picks the view.
// - Byte insert to lane 3 writes the core byte there only.
// - Scalars of 8 to 64 bits; non-multiplies reach any element.
// - Multiply 16-bit scalar only from doubles 0-7, lane 0-3.
// - Multiply 32-bit scalar only doubles 0-15, lane 0-1.
// - Tags pair a letter with a width from the allowed table.
// - Sixteen-register config: scalar FP sees D0-15 and S0-31.
// - Thirty-two config: scalar FP sees all 32 doubles.
// - With half option a single register holds a 16-bit float.
// - Scalar FP has 16/32 integers, 16/32/64 floats, no 64 integer.
// - Unit is file plus integer, float and load/permute pipelines.
`timescale 1ns/100ps
`default_nettype none
module svrf_regfile
#(
	parameter int NUM_DBL = 32,
	parameter bit HALF_OPT = 1'b1
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Vector port: integer, float or load/permute pipeline
	input wire logic vec_req,
	input wire svrf_pkg::svrf_client_t vec_client,
	input wire svrf_pkg::svrf_view_t vec_view,
	input wire logic vec_we,
	input wire logic [4:0] vec_reg,
	input wire logic [127:0] vec_wdata,
	output logic [127:0] vec_rdata,
	output logic vec_err,
	// Vector lane execute: dst = srcA op srcB in double view
	input wire logic exe_req,
	input wire svrf_pkg::svrf_op_t exe_op,
	input wire svrf_pkg::svrf_width_t exe_width,
	input wire svrf_pkg::svrf_kind_t exe_kind,
	input wire logic [4:0] exe_dst,
	input wire logic [4:0] exe_src_a,
	input wire logic [4:0] exe_src_b,
	input wire logic [31:0] exe_core,
	input wire logic [3:0] exe_lane,
	output logic exe_err,
	// Scalar element read
	input wire logic scl_req,
	input wire logic scl_mul,
	input wire svrf_pkg::svrf_width_t scl_width,
	input wire logic [4:0] scl_reg,
	input wire logic [3:0] scl_lane,
	output logic [63:0] scl_data,
	output logic scl_err,
	// Scalar floating-point unit port
	input wire logic sfp_req,
	input wire svrf_pkg::svrf_view_t sfp_view,
	input wire svrf_pkg::svrf_kind_t sfp_kind,
	input wire svrf_pkg::svrf_width_t sfp_width,
	input wire logic sfp_we,
	input wire logic [4:0] sfp_reg,
	input wire logic [63:0] sfp_wdata,
	output logic [63:0] sfp_rdata,
	output logic sfp_err
);
	////////////////////////////////////////////////////////////////////////
	// Parameter checks

	// Refused at elaboration so no odd double count ever builds
	if (NUM_DBL != svrf_pkg::NUM_DBL_FULL &&
		NUM_DBL != svrf_pkg::NUM_DBL_SMALL)
	begin : g_bad_num_dbl
		$error("NUM_DBL must be 16 or 32");
	end

	////////////////////////////////////////////////////////////////////////
	// Storage: one 128-bit word per quad register

	logic [127:0] store [svrf_pkg::NUM_QUAD];
	logic [5:0] num_dbl_c;
	assign num_dbl_c = 6'(NUM_DBL);

	// Double-view read: even index low half, odd high half
	function automatic logic [63:0] dbl_rd(input logic [4:0] r,
		input logic [127:0] w);
		dbl_rd = r[0] ? w[127:64] : w[63:0];
	endfunction : dbl_rd

	// Does a request reach beyond the configured double count
	function automatic logic dbl_out(input logic [4:0] r, input logic [5:0] n);
		dbl_out = {1'b0, r} >= n;
	endfunction : dbl_out

	////////////////////////////////////////////////////////////////////////
	// Vector port decode

	logic vec_bad;
	logic [3:0] vec_q;
	always_comb
	begin
		vec_q = vec_view == svrf_pkg::SVRF_VIEW_Q ? vec_reg[3:0] : vec_reg[4:1];
		case (vec_view)
			svrf_pkg::SVRF_VIEW_Q: vec_bad = vec_reg[4];
			svrf_pkg::SVRF_VIEW_D: vec_bad = dbl_out(vec_reg, num_dbl_c);
			default: vec_bad = 1'b1;
		endcase
		if (vec_client == svrf_pkg::SVRF_C_SFP)
			vec_bad = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Execute path: lane ALU and byte insert

	logic [63:0] exe_a;
	logic [63:0] exe_b;
	logic [63:0] alu_y;
	logic [63:0] ins_y;
	logic [63:0] exe_y;
	logic exe_tag_ok;
	logic exe_bad;
	logic [6:0] lane_cnt;

	assign exe_a = dbl_rd(exe_src_a, store[exe_src_a[4:1]]);
	assign exe_b = dbl_rd(exe_src_b, store[exe_src_b[4:1]]);

	svrf_lane_alu u_alu
	(
		.a(exe_a),
		.b(exe_b),
		.sub(exe_op == svrf_pkg::SVRF_OP_SUB),
		.width(exe_width),
		.y(alu_y)
	);

	svrf_tag_check u_exe_tag
	(
		.kind(exe_kind),
		.width(exe_width),
		.scalar_fp(1'b0),
		.half_opt(HALF_OPT),
		.legal(exe_tag_ok)
	);

	// Insert the low bits of the core register into one lane of srcA
	always_comb
	begin
		ins_y = exe_a;
		case (exe_width)
			svrf_pkg::SVRF_W8: ins_y[8*exe_lane[2:0] +: 8] = exe_core[7:0];
			svrf_pkg::SVRF_W16: ins_y[16*exe_lane[1:0] +: 16] = exe_core[15:0];
			svrf_pkg::SVRF_W32: ins_y[32*exe_lane[0] +: 32] = exe_core;
			default: ins_y = {32'h0, exe_core};
		endcase
		case (exe_op)
			svrf_pkg::SVRF_OP_ADD,
			svrf_pkg::SVRF_OP_SUB: exe_y = alu_y;
			svrf_pkg::SVRF_OP_INS: exe_y = ins_y;
			default: exe_y = exe_a;
		endcase
	end

	// Lanes per 64-bit vector for the chosen width
	always_comb
	begin
		case (exe_width)
			svrf_pkg::SVRF_W8: lane_cnt = 7'd8;
			svrf_pkg::SVRF_W16: lane_cnt = 7'd4;
			svrf_pkg::SVRF_W32: lane_cnt = 7'd2;
			default: lane_cnt = 7'd1;
		endcase
	end

	assign exe_bad = !exe_tag_ok || dbl_out(exe_dst, num_dbl_c) ||
		dbl_out(exe_src_a, num_dbl_c) || dbl_out(exe_src_b, num_dbl_c) ||
		((exe_op == svrf_pkg::SVRF_OP_INS) &&
		({3'h0, exe_lane} >= lane_cnt));

	////////////////////////////////////////////////////////////////////////
	// Scalar element select

	logic [127:0] scl_word;
	logic [63:0] scl_val;
	logic [5:0] scl_lanes;
	logic scl_bad;
	assign scl_word = store[scl_reg[4:1]];

	// Lane 0 at the lowest bits of the double register
	always_comb
	begin
		scl_val = 64'h0;
		scl_lanes = 6'd1;
		case (scl_width)
			svrf_pkg::SVRF_W8:
			begin
				scl_val = {56'h0, 8'(dbl_rd(scl_reg, scl_word) >>
					(8*scl_lane[2:0]))};
				scl_lanes = 6'd8;
			end
			svrf_pkg::SVRF_W16:
			begin
				scl_val = {48'h0, 16'(dbl_rd(scl_reg, scl_word) >> (16*scl_lane[1:0]))};
				scl_lanes = 6'd4;
			end
			svrf_pkg::SVRF_W32:
			begin
				scl_val = {32'h0, 32'(dbl_rd(scl_reg, scl_word) >> (32*scl_lane[0]))};
				scl_lanes = 6'd2;
			end
			default: scl_val = dbl_rd(scl_reg, scl_word);
		endcase
		scl_bad = dbl_out(scl_reg, num_dbl_c) || ({2'h0, scl_lane} >= scl_lanes);
		if (scl_mul)
		begin
			case (scl_width)
				svrf_pkg::SVRF_W16: scl_bad = scl_bad ||
					(32'(scl_reg) > svrf_pkg::MUL16_MAX_REG) ||
					(32'(scl_lane) > svrf_pkg::MUL16_MAX_LANE);
				svrf_pkg::SVRF_W32: scl_bad = scl_bad ||
					(32'(scl_reg) > svrf_pkg::MUL32_MAX_REG) ||
					(32'(scl_lane) > svrf_pkg::MUL32_MAX_LANE);
				default: scl_bad = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scalar floating-point port decode

	logic sfp_tag_ok;
	logic sfp_bad;
	logic [63:0] sfp_val;

	svrf_tag_check u_sfp_tag
	(
		.kind(sfp_kind),
		.width(sfp_width),
		.scalar_fp(1'b1),
		.half_opt(HALF_OPT),
		.legal(sfp_tag_ok)
	);

	// Singles overlay the low sixteen doubles whatever the configuration
	always_comb
	begin
		case (sfp_view)
			svrf_pkg::SVRF_VIEW_S:
			begin
				sfp_val = {32'h0, store[sfp_reg[4:2]][32*sfp_reg[1:0] +: 32]};
				sfp_bad = !sfp_tag_ok || (sfp_width == svrf_pkg::SVRF_W64);
			end
			svrf_pkg::SVRF_VIEW_D:
			begin
				sfp_val = dbl_rd(sfp_reg, store[sfp_reg[4:1]]);
				sfp_bad = !sfp_tag_ok || dbl_out(sfp_reg, num_dbl_c);
			end
			default:
			begin
				sfp_val = 64'h0;
				sfp_bad = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Storage update; views merge into one word, untouched bits kept

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			for (int k = 0; k < svrf_pkg::NUM_QUAD; k++)
				store[k] <= svrf_pkg::STORE_RESET;
		end
		else
		begin
			// Vector writes first, then execute, then scalar FP last wins
			if (vec_req && vec_we && !vec_bad)
			begin
				if (vec_view == svrf_pkg::SVRF_VIEW_Q)
					store[vec_q] <= vec_wdata;
				else
					store[vec_q][64*vec_reg[0] +: 64] <= vec_wdata[63:0];
			end
			if (exe_req && !exe_bad)
				store[exe_dst[4:1]][64*exe_dst[0] +: 64] <= exe_y;
			if (sfp_req && sfp_we && !sfp_bad)
			begin
				if (sfp_view == svrf_pkg::SVRF_VIEW_S)
					store[sfp_reg[4:2]][32*sfp_reg[1:0] +: 32] <= sfp_wdata[31:0];
				else
					store[sfp_reg[4:1]][64*sfp_reg[0] +: 64] <= sfp_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered read data and error flags

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			vec_rdata <= 128'h0;
			vec_err <= 1'b0;
		end
		else
		begin
			vec_err <= vec_req && vec_bad;
			if (vec_req && !vec_bad)
				vec_rdata <= vec_view == svrf_pkg::SVRF_VIEW_Q ? store[vec_q] :
					{64'h0, dbl_rd(vec_reg, store[vec_q])};
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			exe_err <= 1'b0;
		else
			exe_err <= exe_req && exe_bad;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			scl_data <= 64'h0;
			scl_err <= 1'b0;
		end
		else
		begin
			scl_err <= scl_req && scl_bad;
			if (scl_req && !scl_bad)
				scl_data <= scl_val;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sfp_rdata <= 64'h0;
			sfp_err <= 1'b0;
		end
		else
		begin
			sfp_err <= sfp_req && sfp_bad;
			if (sfp_req && !sfp_bad)
				sfp_rdata <= sfp_val;
		end
	end
endmodule : svrf_regfile
`default_nettype wire

// ==== tb/svrf_regfile_props.sv ====
// Port checker for the vector register file: refusals, scalar reach
// and read-data hold. Bound to svrf_regfile; one clock, sync reset.
`timescale 1ns/100ps
`default_nettype none
module svrf_regfile_props
#(
	parameter int NUM_DBL = 32
)
(
	// Clock, reset and requests
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic vec_req,
	input wire logic exe_req,
	input wire logic scl_req,
	input wire logic scl_mul,
	input wire logic sfp_req,
	// Request fields
	input wire svrf_pkg::svrf_client_t vec_client,
	input wire svrf_pkg::svrf_view_t vec_view,
	input wire logic [4:0] vec_reg,
	input wire svrf_pkg::svrf_width_t exe_width,
	input wire svrf_pkg::svrf_kind_t exe_kind,
	input wire svrf_pkg::svrf_width_t scl_width,
	input wire logic [4:0] scl_reg,
	input wire logic [3:0] scl_lane,
	input wire svrf_pkg::svrf_kind_t sfp_kind,
	input wire svrf_pkg::svrf_width_t sfp_width,
	// Answers
	input wire logic [127:0] vec_rdata,
	input wire logic vec_err,
	input wire logic exe_err,
	input wire logic scl_err,
	input wire logic sfp_err
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////
	// A refusal shows as an error in the very next cycle
	sequence s_err(e);
		##1 e;
	endsequence
	// Multiply scalar asked outside its reach
	sequence s_mul_far;
		scl_req && scl_mul && (scl_width == 2'h1 ?
			(scl_reg > 5'd7 || scl_lane > 4'd3) :
			(scl_reg > 5'd15 || scl_lane > 4'd1));
	endsequence
	property p_vec_s;
		vec_req && (vec_view == 2'h0 || vec_client == 2'h3)
			|-> s_err(vec_err);
	endproperty
	a_vec_s: assert property (p_vec_s)
		else $error("single view access not refused");
	property p_quad_rng;
		vec_req && vec_view == 2'h2 && vec_reg[4] |-> s_err(vec_err);
	endproperty
	a_quad_rng: assert property (p_quad_rng)
		else $error("quad number above 15 not refused");
	property p_mul_far;
		s_mul_far |-> s_err(scl_err);
	endproperty
	a_mul_far: assert property (p_mul_far)
		else $error("multiply scalar out of reach not refused");
	property p_mul_w;
		scl_req && scl_mul && scl_width[0] == scl_width[1]
			|-> s_err(scl_err);
	endproperty
	a_mul_w: assert property (p_mul_w)
		else $error("multiply scalar width not refused");
	property p_scl_ok;
		scl_req && !scl_mul && scl_reg < NUM_DBL
			&& scl_lane < (4'd8 >> scl_width) |=> !scl_err;
	endproperty
	a_scl_ok: assert property (p_scl_ok)
		else $error("legal scalar element refused");
	property p_tag;
		exe_req && (exe_kind == 3'h3 && exe_width[0] == exe_width[1]
			|| exe_kind == 3'h4 && exe_width[1]) |-> s_err(exe_err);
	endproperty
	a_tag: assert property (p_tag)
		else $error("illegal element tag not refused");
	property p_sfp_tag;
		sfp_req && (sfp_width == 2'h0 || sfp_kind != 3'h3
			&& sfp_width == 2'h3) |-> s_err(sfp_err);
	endproperty
	a_sfp_tag: assert property (p_sfp_tag)
		else $error("scalar 64-bit integer not refused");
	// Read data stands until another request, read or write, is taken
	property p_hold;
		!vec_req |=> $stable(vec_rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a request");
endmodule : svrf_regfile_props
bind svrf_regfile svrf_regfile_props #(.NUM_DBL(NUM_DBL)) u_props (
	.mclk(mclk), .sys_rst(sys_rst), .vec_req(vec_req),
	.exe_req(exe_req), .scl_req(scl_req), .scl_mul(scl_mul),
	.sfp_req(sfp_req), .vec_client(vec_client), .vec_view(vec_view),
	.vec_reg(vec_reg), .exe_width(exe_width), .exe_kind(exe_kind),
	.scl_width(scl_width), .scl_reg(scl_reg), .scl_lane(scl_lane),
	.sfp_kind(sfp_kind), .sfp_width(sfp_width),
	.vec_rdata(vec_rdata), .vec_err(vec_err), .exe_err(exe_err),
	.scl_err(scl_err), .sfp_err(sfp_err));
`default_nettype wire

// ==== tb/svrf_pipe_model.sv ====
// Vector pipeline model: issues quad and double accesses on the
// vector port. Assumes the file takes a request at the rising edge.
`timescale 1ns/100ps
`default_nettype none
module svrf_pipe_model
(
	// Clock
	input wire logic mclk,
	// Vector port towards the register file
	output logic vec_req,
	output var svrf_pkg::svrf_client_t vec_client,
	output var svrf_pkg::svrf_view_t vec_view,
	output logic vec_we,
	output logic [4:0] vec_reg,
	output logic [127:0] vec_wdata
);
	// Idle port at time zero
	initial
	begin
		vec_req = 1'b0;
		vec_client = svrf_pkg::SVRF_C_INT;
		vec_view = svrf_pkg::SVRF_VIEW_Q;
		vec_we = 1'b0;
		vec_reg = 5'h0;
		vec_wdata = 128'h0;
	end
	// One access; released data is inverted so it never looks valid
	task automatic acc(input svrf_pkg::svrf_client_t c,
		input svrf_pkg::svrf_view_t v, input logic we,
		input logic [4:0] r, input logic [127:0] wd);
		@(posedge mclk);
		vec_req <= 1'b1;
		vec_client <= c;
		vec_view <= v;
		vec_we <= we;
		vec_reg <= r;
		vec_wdata <= wd;
		@(posedge mclk);
		vec_req <= 1'b0;
		vec_wdata <= ~wd;
		#1;
	endtask : acc
endmodule : svrf_pipe_model
`default_nettype wire

// ==== tb/svrf_regfile_tb.sv ====
// Self-checking bench for the vector register file: views, lanes,
// scalar reach, tags and refusals against a shadow of the storage.
// Assumes the pipeline model owns the vector port.
`timescale 1ns/100ps
`default_nettype none
module svrf_regfile_tb;
	localparam svrf_pkg::svrf_view_t VS = svrf_pkg::SVRF_VIEW_S;
	localparam svrf_pkg::svrf_view_t VD = svrf_pkg::SVRF_VIEW_D;
	localparam svrf_pkg::svrf_view_t VQ = svrf_pkg::SVRF_VIEW_Q;
	localparam svrf_pkg::svrf_kind_t KU = svrf_pkg::SVRF_K_UNSIGNED;
	localparam svrf_pkg::svrf_kind_t KF = svrf_pkg::SVRF_K_FLOAT;
	localparam svrf_pkg::svrf_client_t CI = svrf_pkg::SVRF_C_INT;
	// Multiply scalar cases: width code, register, lane, refused
	localparam int MW[8] = '{1, 1, 1, 2, 2, 2, 0, 3};
	localparam int MR[8] = '{7, 8, 0, 15, 16, 0, 0, 0};
	localparam int ML[8] = '{3, 0, 4, 1, 0, 2, 0, 0};
	localparam int ME[8] = '{0, 1, 1, 0, 1, 1, 1, 1};
	logic mclk, sys_rst, vec_req, vec_we, vec_err, exe_req, exe_err;
	logic scl_req, scl_mul, scl_err, sfp_req, sfp_we, sfp_err;
	logic v16_err, f16_err;
	svrf_pkg::svrf_client_t vec_client;
	svrf_pkg::svrf_view_t vec_view, sfp_view;
	svrf_pkg::svrf_op_t exe_op;
	svrf_pkg::svrf_width_t exe_width, scl_width, sfp_width;
	svrf_pkg::svrf_kind_t exe_kind, sfp_kind;
	logic [4:0] vec_reg, exe_dst, exe_src_a, exe_src_b, scl_reg, sfp_reg;
	logic [3:0] exe_lane, scl_lane;
	logic [31:0] exe_core;
	logic [63:0] sfp_wdata, sfp_rdata, scl_data, e;
	logic [127:0] vec_wdata, vec_rdata;
	logic [127:0] q[16];
	int fail_count, num_checks, cyc, d, k, r, w;
	int seed = 32'hff35df37;

	svrf_regfile #(.NUM_DBL(32), .HALF_OPT(1'b1)) dut (.*);
	svrf_pipe_model pm (.*);
	// Reduced file without the half option; shares every input
	svrf_regfile #(.NUM_DBL(16), .HALF_OPT(1'b0)) dut16 (.*,
		.vec_rdata(), .vec_err(v16_err), .exe_err(), .scl_data(),
		.scl_err(), .sfp_rdata(), .sfp_err(f16_err));

	////////////////////////
	// Shadow double view
	function automatic logic [63:0] dget(input int n);
		return q[n / 2][(n % 2) * 64 +: 64];
	endfunction : dget
	// Lane add or subtract; the carry restarts at each lane edge
	function automatic logic [63:0] ladd(input logic [63:0] a, b,
		input logic s, input int wb);
		logic c;
		logic bb;
		logic [63:0] y;
		for (int i = 0; i < 64; i++)
		begin
			if (i % wb == 0)
				c = s;
			bb = b[i] ^ s;
			y[i] = a[i] ^ bb ^ c;
			c = (a[i] & bb) | (c & (a[i] ^ bb));
		end
		return y;
	endfunction : ladd
	// Element l of width wb in double n, zero-extended
	function automatic logic [63:0] elem(input int n, l, wb);
		logic [63:0] m;
		m = (wb == 64) ? '1 : (64'h1 << wb) - 64'h1;
		return (dget(n) >> (l * wb)) & m;
	endfunction : elem

	////////////////////////
	task automatic chk(input logic [127:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Drop every bench request after the taking edge
	task automatic fin;
		@(posedge mclk);
		exe_req <= 1'b0;
		scl_req <= 1'b0;
		sfp_req <= 1'b0;
		#1;
	endtask : fin
	task automatic exe(input svrf_pkg::svrf_op_t op,
		input svrf_pkg::svrf_kind_t kd, input int wc, n, a, b, l);
		@(posedge mclk);
		exe_req <= 1'b1;
		exe_op <= op;
		exe_kind <= kd;
		exe_width <= svrf_pkg::svrf_width_t'(wc);
		exe_dst <= 5'(n);
		exe_src_a <= 5'(a);
		exe_src_b <= 5'(b);
		exe_lane <= 4'(l);
		exe_core <= $random(seed);
		fin;
	endtask : exe
	task automatic scl(input logic m, input int wc, n, l);
		@(posedge mclk);
		scl_req <= 1'b1;
		scl_mul <= m;
		scl_width <= svrf_pkg::svrf_width_t'(wc);
		scl_reg <= 5'(n);
		scl_lane <= 4'(l);
		fin;
	endtask : scl
	task automatic sfp(input svrf_pkg::svrf_view_t v,
		input svrf_pkg::svrf_kind_t kd, input int wc, n, input logic we);
		@(posedge mclk);
		sfp_req <= 1'b1;
		sfp_view <= v;
		sfp_kind <= kd;
		sfp_width <= svrf_pkg::svrf_width_t'(wc);
		sfp_we <= we;
		sfp_reg <= 5'(n);
		sfp_wdata <= {$random(seed), $random(seed)};
		fin;
	endtask : sfp
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Ceiling well above the roughly 340 cycles the tests take
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			$display("MISMATCH t=%0t timeout", $time);
			wrap_up;
		end
	end
	// Main sequence
	initial
	begin
		sys_rst = 1'b1;
		{exe_req, scl_req, scl_mul, sfp_req, sfp_we} = '0;
		exe_op = svrf_pkg::SVRF_OP_PASS;
		exe_width = svrf_pkg::SVRF_W8;
		scl_width = exe_width;
		sfp_width = exe_width;
		exe_kind = KU;
		sfp_kind = KU;
		sfp_view = VS;
		{exe_dst, exe_src_a, exe_src_b, scl_reg, sfp_reg} = '0;
		{exe_lane, scl_lane, exe_core, sfp_wdata} = '0;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		pm.acc(CI, VQ, 1'b0, 5'h0, '0);
		chk(vec_rdata, svrf_pkg::STORE_RESET);
		for (int i = 0; i < 16; i++)
		begin
			q[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
			pm.acc(svrf_pkg::svrf_client_t'(i % 3), VQ, 1'b1, 5'(i), q[i]);
		end
		for (int i = 0; i < 16; i++)
		begin
			pm.acc(CI, VQ, 1'b0, 5'(i), '0);
			chk(vec_rdata, q[i]);
		end
		for (int i = 0; i < 32; i++)
		begin
			pm.acc(svrf_pkg::SVRF_C_LSP, VD, 1'b0, 5'(i), '0);
			chk(vec_rdata, {64'h0, dget(i)});
		end
		$display("views done");
		repeat (8)
		begin
			k = $random(seed) & 31;
			sfp(VS, KU, 2, k, 1'b1);
			e = sfp_wdata;
			q[k / 4][(k % 4) * 32 +: 32] = e[31:0];
			sfp(VS, KF, 2, k, 1'b0);
			chk(128'(sfp_rdata), 128'(e[31:0]));
			pm.acc(CI, VQ, 1'b0, 5'(k / 4), '0);
			chk(vec_rdata, q[k / 4]);
			sfp(VD, KF, 3, k, 1'b0);
			chk(128'(sfp_rdata), 128'(dget(k)));
			sfp(VS, KF, 1, k, 1'b0);
			chk(128'(sfp_err), 128'h0);
		end
		$display("singles done");
		for (int i = 0; i < 12; i++)
		begin
			w = i % 4;
			r = $random(seed) & 31;
			k = $random(seed) & 31;
			d = $random(seed) & 31;
			e = (i % 3 == 0) ? dget(r) :
				ladd(dget(r), dget(k), i % 3 == 2, 8 << w);
			exe(svrf_pkg::svrf_op_t'(i % 3), KU, w, d, r, k, 0);
			q[d / 2][(d % 2) * 64 +: 64] = e;
			pm.acc(CI, VD, 1'b0, 5'(d), '0);
			chk(vec_rdata, {64'h0, e});
		end
		exe(svrf_pkg::SVRF_OP_INS, KU, 0, 0, 0, 0, 3);
		q[0][31:24] = exe_core[7:0];
		exe(svrf_pkg::SVRF_OP_INS, KU, 0, 0, 0, 0, 8);
		chk(128'(exe_err), 128'h1);
		exe(svrf_pkg::SVRF_OP_PASS, KF, 0, 1, 2, 0, 0);
		chk(128'(exe_err), 128'h1);
		exe(svrf_pkg::SVRF_OP_PASS, svrf_pkg::SVRF_K_POLY, 2, 1, 2, 0, 0);
		chk(128'(exe_err), 128'h1);
		pm.acc(CI, VD, 1'b0, 5'h0, '0);
		chk(vec_rdata, {64'h0, dget(0)});
		pm.acc(CI, VD, 1'b0, 5'h1, '0);
		chk(vec_rdata, {64'h0, dget(1)});
		$display("lanes done");
		repeat (8)
		begin
			w = $random(seed) & 3;
			r = $random(seed) & 31;
			k = ($random(seed) & 7) >> w;
			scl(1'b0, w, r, k);
			chk(128'(scl_data), 128'(elem(r, k, 8 << w)));
		end
		for (int i = 0; i < 8; i++)
		begin
			scl(1'b1, MW[i], MR[i], ML[i]);
			chk(128'(scl_err), 128'(ME[i]));
		end
		$display("scalars done");
		pm.acc(CI, VQ, 1'b1, 5'd16, '1);
		chk(128'(vec_err), 128'h1);
		pm.acc(CI, VS, 1'b1, 5'd0, '1);
		chk(128'(vec_err), 128'h1);
		pm.acc(svrf_pkg::SVRF_C_SFP, VD, 1'b1, 5'd0, '1);
		chk(128'(vec_err), 128'h1);
		sfp(VD, KU, 3, 0, 1'b1);
		chk(128'(sfp_err), 128'h1);
		pm.acc(CI, VD, 1'b0, 5'd16, '0);
		chk(128'(v16_err), 128'h1);
		chk(vec_rdata, {64'h0, dget(16)});
		sfp(VS, KF, 1, 0, 1'b0);
		chk(128'(f16_err), 128'h1);
		sfp(VD, KF, 3, 16, 1'b0);
		chk(128'(f16_err), 128'h1);
		chk(128'(sfp_rdata), 128'(dget(16)));
		pm.acc(CI, VQ, 1'b0, 5'h0, '0);
		chk(vec_rdata, q[0]);
		$display("refusals done");
		wrap_up;
	end
endmodule : svrf_regfile_tb
`default_nettype wire
